// File: logic/thw_pkg.sv
// package: register map, field layout and carriers of the three-wire serial port
package thw_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PORT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;

  // control register fields
  localparam int CTRL_CK_LO = 0;
  localparam int CTRL_CK_HI = 1;
  localparam int CTRL_SOE   = 2;
  localparam int CTRL_START = 3;

  // port register fields
  localparam int PORT_IN_DIR  = 0;
  localparam int PORT_OUT_DIR = 1;
  localparam int PORT_CLK_DIR = 2;
  localparam int PORT_IN_LAT  = 4;
  localparam int PORT_OUT_LAT = 5;
  localparam int PORT_CLK_LAT = 6;

  // status register fields
  localparam int STAT_CNT = 0;
  localparam int STAT_SI  = 4;
  localparam int STAT_SO  = 5;
  localparam int STAT_SCK = 6;

  // reset values and counts
  localparam logic [3:0] CTRL_RST      = 4'h0;
  localparam logic [5:0] PORT_RST      = 6'h00;
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  localparam int         SCK_HALF_DEF  = 8;

  // control bits steering the port
  typedef struct packed {
    logic start;
    logic soe;
    logic ck_hi;
    logic ck_lo;
  } thw_ctrl_s;

  // pin directions and output latches
  typedef struct packed {
    logic lat_clk;
    logic lat_out;
    logic lat_in;
    logic clk_pin_dir;
    logic out_pin_dir;
    logic in_pin_dir;
  } thw_port_s;

  // one pin's drive level and enable
  typedef struct packed {
    logic o;
    logic oe;
  } thw_pin_s;

endpackage

// File: logic/thw_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
module thw_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,     // system clock
  input  wire logic         sys_rst, // async reset, active high
  input  wire logic [W-1:0] d,       // asynchronous levels
  output logic      [W-1:0] q        // synchronised levels
);

  logic [W-1:0] meta;

  generate
    if (W < 1)
    begin : g_chk
      $error("thw_sync: width must be at least one");
    end
  endgenerate

  // first stage feeds only the second
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// File: logic/thw_clkdiv.sv
// internal shift clock divider for master operation
`timescale 1ns/100ps
module thw_clkdiv #(
  parameter int HALF = thw_pkg::SCK_HALF_DEF
) (
  input  wire logic clk,     // system clock
  input  wire logic sys_rst, // async reset, active high
  input  wire logic run,     // toggle while high, idle high otherwise
  input  wire logic hold,    // park high once reached
  output logic      level    // internal shift clock level
);

  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;

  logic [CW-1:0] cnt;

  // edge detection on the read-back pin lags by about four cycles
  generate
    if (HALF < 4)
    begin : g_chk
      $error("thw_clkdiv: half period must be at least four cycles");
    end
  endgenerate

  // half-period counter and clock level
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt   <= '0;
      level <= 1'b1;
    end
    else if (!run)
    begin
      cnt   <= '0;
      level <= 1'b1;
    end
    else if (hold && level)
    begin
      cnt <= '0;
    end
    else if (cnt == CW'(HALF - 1))
    begin
      cnt   <= '0;
      level <= ~level;
    end
    else
    begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule

// File: logic/thw_serial_port.sv
// three-wire eight-bit serial port with APB registers and pin control
// Function
// - both clock-select bits zero means slave, any other setting means master
// - in wait the clock pin is a plain port per its direction bit
// - slave with wait released floats the clock pin for the external clock
// - master with wait released drives the internal clock regardless of direction
// - released, output enabled, direction one: drive serial data; direction zero floats
// - output enable zero: output pin is a plain port per its direction
// - bit counter increments on each falling edge of the clock pin
// - with output enabled, shift out MSB first at each falling edge
// - capture the input pin into the LSB at each rising edge
// - input direction one drives the latch there, and that value shifts in
// - rising edge with counter at eight clears start flag, back to wait
// - power-on, chip-enable reset and clock stop float all serial pins
// - shifter contents are undefined after power-on reset
// - clock stop and chip-enable reset keep the shifter contents
// - during halt every serial pin keeps its configuration
// - master stops emitting its internal clock once halted
// - shift logic keeps working in halt when an external clock arrives
// - writing zero to start flag forces wait and clears the counter
// - shifter does not shift while in wait
// - after eight clocks master parks clock high, counter and shifter stop
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module thw_serial_port #(
  parameter int SCK_HALF = thw_pkg::SCK_HALF_DEF
) (
  input  wire logic        clk,       // system clock, 25 MHz
  input  wire logic        sys_rst,   // async reset, active high
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb access phase
  input  wire logic        pwrite,    // apb write
  input  wire logic [7:0]  paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  output logic      [31:0] prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // apb error, unmapped address
  input  wire logic        cpu_halt,  // processor in halt
  input  wire logic        clk_stop,  // clock stop instruction pulse
  input  wire logic        ce_reset,  // chip-enable reset pulse
  input  wire logic        sck_i,     // clock pin level
  output logic             sck_o,     // clock pin drive
  output logic             sck_oe,    // clock pin enable
  input  wire logic        so_i,      // serial out pin level
  output logic             so_o,      // serial out pin drive
  output logic             so_oe,     // serial out pin enable
  input  wire logic        si_i,      // serial in pin level
  output logic             si_o,      // serial in pin drive
  output logic             si_oe      // serial in pin enable
);

  thw_pkg::thw_ctrl_s ctrl;
  thw_pkg::thw_port_s port;
  thw_pkg::thw_pin_s  next_sck;
  thw_pkg::thw_pin_s  next_so;
  thw_pkg::thw_pin_s  next_si;
  logic [2:0]         pin_q;
  logic               sck_q;
  logic [3:0]         bit_cnt;
  logic [7:0]         presettable_shifter;
  logic               so_bit;
  logic               int_sck;
  logic [31:0]        next_prdata;
  logic               addr_hit;
  logic               master;
  logic               stop_evt;
  logic               sck_rise;
  logic               sck_fall;
  logic               rise_ok;
  logic               fall_ok;
  logic               end_xfer;
  logic               at_last;
  logic               in_bit;
  logic               acc;
  logic               wr_ctrl;
  logic               wr_port;
  logic               wr_data;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and shift clock edges

  // pin levels pass two flops, order sck, so, si
  thw_sync #(
    .W (3)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({sck_i, so_i, si_i}),
    .q       (pin_q)
  );

  // previous synchronised clock level
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sck_q <= 1'b0;
    else
      sck_q <= pin_q[2];
  end

  // edges of the clock pin, read back in master too
  assign sck_rise = pin_q[2] & ~sck_q;
  assign sck_fall = ~pin_q[2] & sck_q;
  assign at_last  = (bit_cnt == thw_pkg::BITS_PER_XFER);
  // a rise before the first fall is the pin leaving its idle level
  assign rise_ok  = ctrl.start & sck_rise & (bit_cnt != 4'h0);
  assign fall_ok  = ctrl.start & sck_fall & ~at_last;
  assign end_xfer = rise_ok & at_last;
  assign master   = ctrl.ck_hi | ctrl.ck_lo;
  assign stop_evt = clk_stop | ce_reset;
  // driven input pin shifts in its own latch
  assign in_bit   = port.in_pin_dir ? port.lat_in : pin_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  // write strobes in the access phase
  assign acc     = psel & penable;
  assign wr_ctrl = acc & pwrite & (paddr == thw_pkg::ADDR_CTRL);
  assign wr_port = acc & pwrite & (paddr == thw_pkg::ADDR_PORT);
  assign wr_data = acc & pwrite & (paddr == thw_pkg::ADDR_DATA);
  assign addr_hit = (paddr == thw_pkg::ADDR_CTRL) | (paddr == thw_pkg::ADDR_PORT) |
                    (paddr == thw_pkg::ADDR_DATA) | (paddr == thw_pkg::ADDR_STAT);

  // read data chosen in the setup phase
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      thw_pkg::ADDR_CTRL:
        next_prdata[3:0] = ctrl;
      thw_pkg::ADDR_PORT:
      begin
        next_prdata[thw_pkg::PORT_IN_DIR]  = port.in_pin_dir;
        next_prdata[thw_pkg::PORT_OUT_DIR] = port.out_pin_dir;
        next_prdata[thw_pkg::PORT_CLK_DIR] = port.clk_pin_dir;
        next_prdata[thw_pkg::PORT_IN_LAT]  = port.lat_in;
        next_prdata[thw_pkg::PORT_OUT_LAT] = port.lat_out;
        next_prdata[thw_pkg::PORT_CLK_LAT] = port.lat_clk;
      end
      thw_pkg::ADDR_DATA:
        next_prdata[7:0] = presettable_shifter;
      thw_pkg::ADDR_STAT:
      begin
        next_prdata[thw_pkg::STAT_CNT +: 4] = bit_cnt;
        next_prdata[thw_pkg::STAT_SI]       = pin_q[0];
        next_prdata[thw_pkg::STAT_SO]       = pin_q[1];
        next_prdata[thw_pkg::STAT_SCK]      = pin_q[2];
      end
      default:
        next_prdata = 32'h0000_0000;
    endcase
  end

  // zero-wait answer: ready, data and error stand in the access phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_hit;
      prdata  <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, port and counter state

  // control bits; a software write wins over the end-of-transfer clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl <= thw_pkg::CTRL_RST;
    else if (stop_evt)
      ctrl <= thw_pkg::CTRL_RST;
    else if (wr_ctrl)
    begin
      ctrl.ck_lo <= pwdata[thw_pkg::CTRL_CK_LO];
      ctrl.ck_hi <= pwdata[thw_pkg::CTRL_CK_HI];
      ctrl.soe   <= pwdata[thw_pkg::CTRL_SOE];
      ctrl.start <= pwdata[thw_pkg::CTRL_START];
    end
    else if (end_xfer)
      ctrl.start <= 1'b0;
  end

  // pin directions and latches, all inputs after stop or ce reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      port <= thw_pkg::PORT_RST;
    else if (stop_evt)
      port <= thw_pkg::PORT_RST;
    else if (wr_port)
    begin
      port.in_pin_dir  <= pwdata[thw_pkg::PORT_IN_DIR];
      port.out_pin_dir <= pwdata[thw_pkg::PORT_OUT_DIR];
      port.clk_pin_dir <= pwdata[thw_pkg::PORT_CLK_DIR];
      port.lat_in      <= pwdata[thw_pkg::PORT_IN_LAT];
      port.lat_out     <= pwdata[thw_pkg::PORT_OUT_LAT];
      port.lat_clk     <= pwdata[thw_pkg::PORT_CLK_LAT];
    end
  end

  // bit counter
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bit_cnt <= 4'h0;
    else if (stop_evt)
      bit_cnt <= 4'h0;
    else if (wr_ctrl && !pwdata[thw_pkg::CTRL_START])
      bit_cnt <= 4'h0;
    else if (end_xfer)
      bit_cnt <= 4'h0;
    else if (fall_ok)
      bit_cnt <= bit_cnt + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shifter and serial output bit

  // shifter has no reset and ignores stop and ce reset
  always_ff @(posedge clk)
  begin
    if (wr_data)
      presettable_shifter <= pwdata[7:0];
    else if (rise_ok)
      presettable_shifter <= {presettable_shifter[6:0], in_bit};
  end

  // msb presented at each fall, or at once on a write while clock is low
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      so_bit <= 1'b0;
    else if (wr_data && ctrl.start && !pin_q[2])
      so_bit <= pwdata[7];
    else if (fall_ok)
      so_bit <= presettable_shifter[7];
  end

  // internal clock, stopped by halt and parked high after eight
  thw_clkdiv #(
    .HALF (SCK_HALF)
  ) u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (ctrl.start & master & ~cpu_halt),
    .hold    (at_last),
    .level   (int_sck)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  // pin modes; halt changes nothing here so pins keep their setup
  always_comb
  begin
    next_sck = '{o: port.lat_clk, oe: port.clk_pin_dir};
    if (ctrl.start && master)
      next_sck = '{o: int_sck, oe: 1'b1};
    else if (ctrl.start)
      next_sck = '{o: 1'b0, oe: 1'b0};
    next_so = '{o: port.lat_out, oe: port.out_pin_dir};
    if (ctrl.soe)
      next_so.o = so_bit;
    next_si = '{o: port.lat_in, oe: port.in_pin_dir};
    if (stop_evt)
    begin
      next_sck.oe = 1'b0;
      next_so.oe  = 1'b0;
      next_si.oe  = 1'b0;
    end
  end

  // registered pin outputs, floating from reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_o  <= 1'b0;
      sck_oe <= 1'b0;
      so_o   <= 1'b0;
      so_oe  <= 1'b0;
      si_o   <= 1'b0;
      si_oe  <= 1'b0;
    end
    else
    begin
      sck_o  <= next_sck.o;
      sck_oe <= next_sck.oe;
      so_o   <= next_so.o;
      so_oe  <= next_so.oe;
      si_o   <= next_si.o;
      si_oe  <= next_si.oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_last_rise;
    rise_ok && at_last && !wr_ctrl && !stop_evt;
  endsequence

  sequence s_forced_wait;
    ctrl.start && wr_ctrl && !pwdata[thw_pkg::CTRL_START] && !stop_evt;
  endsequence

  sequence s_halted_master;
    (cpu_halt && master && !wr_ctrl && !stop_evt) [*2];
  endsequence

  slave_clock_float_a : assert property (
    ctrl.start && !master && !stop_evt |=> !sck_oe)
    else $error("clock pin driven in slave transfer");

  master_clock_drive_a : assert property (
    ctrl.start && master && !stop_evt |=> sck_oe && sck_o == $past(int_sck))
    else $error("internal clock not on clock pin");

  wait_clock_port_a : assert property (
    !ctrl.start && !stop_evt |=> sck_oe == $past(port.clk_pin_dir) &&
                                 sck_o == $past(port.lat_clk))
    else $error("clock pin not a plain port in wait");

  serial_data_out_a : assert property (
    ctrl.start && ctrl.soe && !stop_evt |=> so_oe == $past(port.out_pin_dir) &&
                                            so_o == $past(so_bit))
    else $error("serial data not on output pin");

  plain_out_port_a : assert property (
    !ctrl.soe |=> so_o == $past(port.lat_out))
    else $error("output pin carries shift data while disabled");

  count_on_fall_a : assert property (
    fall_ok && !wr_ctrl && !stop_evt |=> bit_cnt == $past(bit_cnt) + 4'h1)
    else $error("counter missed a falling edge");

  msb_out_fall_a : assert property (
    fall_ok && !wr_data ##1 ctrl.soe |=> so_o == $past(presettable_shifter[7], 2))
    else $error("msb not presented after falling edge");

  shift_in_rise_a : assert property (
    rise_ok && !wr_data |=> presettable_shifter[0] == $past(in_bit) &&
      presettable_shifter[7:1] == $past(presettable_shifter[6:0]))
    else $error("input bit not captured on rising edge");

  end_of_xfer_a : assert property (
    s_last_rise |=> !ctrl.start && bit_cnt == 4'h0)
    else $error("transfer did not end after eight bits");

  forced_wait_a : assert property (
    s_forced_wait |=> !ctrl.start && bit_cnt == 4'h0)
    else $error("forced wait did not clear start and counter");

  no_shift_wait_a : assert property (
    !ctrl.start && !wr_data |=> $stable(presettable_shifter))
    else $error("shifter moved in wait");

  stop_floats_a : assert property (
    stop_evt |=> !sck_oe && !so_oe && !si_oe ##1 !ctrl.start && bit_cnt == 4'h0)
    else $error("pins not floated after stop or ce reset");

  halt_no_clock_a : assert property (
    s_halted_master |-> int_sck ##1 int_sck)
    else $error("internal clock still toggling in halt");

  park_high_a : assert property (
    ctrl.start && master && at_last && int_sck && !cpu_halt |=> int_sck)
    else $error("master clock left its high park level");

endmodule

// File: test/thw_peer.sv
// far-side serial device: makes the link clock when the port is slave, swaps one byte
`timescale 1ns/100ps
module thw_peer (
  input  wire logic       run,     // frame active, rising edge loads tx
  input  wire logic       gen,     // peer makes the link clock
  input  wire logic [3:0] ncyc,    // clock periods per frame
  input  wire logic       sck,     // resolved clock pin
  input  wire logic       so,      // resolved serial out pin
  input  wire logic [7:0] tx,      // byte sent to the port
  output logic            sck_gen, // link clock, idles high
  output logic            si,      // data toward the port
  output logic [7:0]      rx       // byte taken from the port
);
  logic [7:0] sh;
  initial
  begin
    sck_gen = 1'b1;
    si = 1'b0;
    rx = 8'h00;
    sh = 8'h00;
  end
  // frame: load the byte, then run the clock only when this side is master
  always @(posedge run)
  begin
    sh = tx;
    #7;
    if (gen)
      repeat (ncyc)
      begin
        #160 sck_gen = 1'b0;
        #160 sck_gen = 1'b1;
      end
  end
  // msb first on each fall
  always @(negedge sck)
    if (run)
    begin
      si = sh[7];
      sh = {sh[6:0], 1'b0};
    end
  // take the port's bit on each rise
  always @(posedge sck)
    if (run)
      rx = {rx[6:0], so};
endmodule

// File: test/tb_top.sv
// self-checking bench of the three-wire serial port
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [1:0] mode; logic halt; logic [7:0] port; logic [7:0] tx; logic [7:0] ptx;
    logic [7:0] exp;
  } thw_xfer_s;
  typedef struct packed {
    logic [7:0] port; logic [3:0] ctrl; logic [2:0] oe; logic [2:0] o;
  } thw_pin_s;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, sck_o, sck_oe, so_o, so_oe, si_o, si_oe, s;
  logic cpu_halt = 0, clk_stop = 0, ce_reset = 0, flt = 0, prun = 0, pgen = 0;
  logic p_sck, p_si;
  logic [7:0] ptx = 0, p_rx;
  logic [3:0] pncyc = 8;
  wire sck_w = sck_oe ? sck_o : (pgen ? p_sck : flt);
  wire so_w = so_oe ? so_o : flt;
  wire si_w = si_oe ? si_o : (prun ? p_si : flt);
  int failures = 0, total_checks = 0, cyc = 0, k;
  thw_xfer_s xr [4] = '{
    '{2'd1, 1'b0, 8'h46, 8'ha5, 8'h3c, 8'h3c}, '{2'd2, 1'b0, 8'h46, 8'h81, 8'h7e, 8'h7e},
    '{2'd3, 1'b0, 8'h57, 8'h5a, 8'hc3, 8'hff}, '{2'd0, 1'b1, 8'h02, 8'h96, 8'h69, 8'h69}};
  thw_pin_s pr [3] = '{'{8'h77, 4'h0, 3'b111, 3'b111}, '{8'h07, 4'h1, 3'b111, 3'b000},
    '{8'h54, 4'h0, 3'b100, 3'b101}};

  thw_serial_port dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_halt(cpu_halt), .clk_stop(clk_stop), .ce_reset(ce_reset),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .so_i(so_w), .so_o(so_o),
    .so_oe(so_oe), .si_i(si_w), .si_o(si_o), .si_oe(si_oe));
  thw_peer peer_u (.run(prun), .gen(pgen), .ncyc(pncyc), .sck(sck_w), .so(so_w),
    .tx(ptx), .sck_gen(p_sck), .si(p_si), .rx(p_rx));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, floating-line pattern and hang guard
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    flt <= ~flt;
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready high ends this wait; if it never rises, only the hang guard ends it
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  // poll until the start flag drops
  task automatic wait_done();
    do
      apb(1'b0, thw_pkg::ADDR_CTRL, 32'h0000_0000);
    while (rd[3] !== 1'b0);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("oe after reset", 3'b000, {sck_oe, so_oe, si_oe});
    rchk("ctrl reset", thw_pkg::ADDR_CTRL, 32'h0000_0000);
    rchk("port reset", thw_pkg::ADDR_PORT, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped err", 1'b1, er);
    // pin setup in wait
    foreach (pr[j])
    begin
      apb(1'b1, thw_pkg::ADDR_PORT, {24'h0, pr[j].port});
      apb(1'b1, thw_pkg::ADDR_CTRL, {28'h0, pr[j].ctrl});
      repeat (3) @(posedge clk);
      chk("wait oe", pr[j].oe, {sck_oe, so_oe, si_oe});
      chk("wait drive", pr[j].o, {sck_o, so_o, si_o});
    end
    // one transfer per clock-select setting
    foreach (xr[j])
    begin
      apb(1'b1, thw_pkg::ADDR_DATA, {24'h0, xr[j].tx});
      apb(1'b1, thw_pkg::ADDR_PORT, {24'h0, xr[j].port});
      pgen <= (xr[j].mode == 2'd0);
      cpu_halt <= xr[j].halt;
      ptx <= xr[j].ptx;
      pncyc <= 4'd8;
      apb(1'b1, thw_pkg::ADDR_CTRL, {28'h0, 2'b11, xr[j].mode});
      repeat (2) @(posedge clk);
      prun <= 1'b1;
      repeat (20) @(posedge clk);
      chk("clk pin drive", xr[j].mode != 2'd0, sck_oe);
      chk("so pin drive", 1'b1, so_oe);
      wait_done();
      prun <= 1'b0;
      cpu_halt <= 1'b0;
      chk("peer byte", xr[j].tx, p_rx);
      rchk("shifted in", thw_pkg::ADDR_DATA, {24'h0, xr[j].exp});
      rchk("start end", thw_pkg::ADDR_CTRL, {28'h0, 2'b01, xr[j].mode});
      apb(1'b0, thw_pkg::ADDR_STAT, 32'h0000_0000);
      chk("count end", 4'h0, rd[3:0]);
    end
    // clocks in wait move nothing
    apb(1'b1, thw_pkg::ADDR_CTRL, 32'h0000_0004);
    prun <= 1'b1;
    repeat (80) @(posedge clk);
    prun <= 1'b0;
    rchk("wait data", thw_pkg::ADDR_DATA, 32'h0000_0069);
    // forced wait after three clocks
    apb(1'b1, thw_pkg::ADDR_CTRL, 32'h0000_000c);
    pncyc <= 4'd3;
    prun <= 1'b1;
    repeat (40) @(posedge clk);
    apb(1'b0, thw_pkg::ADDR_STAT, 32'h0000_0000);
    chk("count three", 4'h3, rd[3:0]);
    apb(1'b1, thw_pkg::ADDR_CTRL, 32'h0000_0004);
    prun <= 1'b0;
    pgen <= 1'b0;
    apb(1'b0, thw_pkg::ADDR_STAT, 32'h0000_0000);
    chk("forced count", 4'h0, rd[3:0]);
    rchk("forced ctrl", thw_pkg::ADDR_CTRL, 32'h0000_0004);
    // halt in mid transfer as master
    apb(1'b1, thw_pkg::ADDR_PORT, 32'h0000_0046);
    apb(1'b1, thw_pkg::ADDR_CTRL, 32'h0000_000d);
    repeat (30) @(posedge clk);
    cpu_halt <= 1'b1;
    repeat (4) @(posedge clk);
    s = sck_o;
    k = 0;
    repeat (40)
    begin
      @(posedge clk);
      if (sck_o !== s)
        k++;
    end
    chk("halt clock", 0, k);
    chk("halt pin", 1'b1, sck_oe);
    cpu_halt <= 1'b0;
    wait_done();
    // data write while the master clock pin is low shows its msb at once
    apb(1'b1, thw_pkg::ADDR_DATA, 32'h0000_0000);
    apb(1'b1, thw_pkg::ADDR_CTRL, 32'h0000_000d);
    do
      apb(1'b0, thw_pkg::ADDR_STAT, 32'h0000_0000);
    while (rd[thw_pkg::STAT_SCK] !== 1'b0);
    apb(1'b1, thw_pkg::ADDR_DATA, 32'h0000_0080);
    repeat (2) @(posedge clk);
    chk("msb on write", 1'b1, so_o);
    wait_done();
    // clock stop and chip-enable reset
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, thw_pkg::ADDR_PORT, 32'h0000_0077);
      apb(1'b1, thw_pkg::ADDR_DATA, 32'h0000_005c);
      clk_stop <= (m == 0);
      ce_reset <= (m == 1);
      @(posedge clk);
      clk_stop <= 1'b0;
      ce_reset <= 1'b0;
      repeat (3) @(posedge clk);
      chk("event oe", 3'b000, {sck_oe, so_oe, si_oe});
      rchk("event port", thw_pkg::ADDR_PORT, 32'h0000_0000);
      rchk("event data", thw_pkg::ADDR_DATA, 32'h0000_005c);
    end
    finish_test();
  end
endmodule
